// *** flash_key_margin_params.svh ***
// constants for the flash key and margin command block
// assumes inclusion by bare name from the design, checker and bench files
`ifndef FLASH_KEY_MARGIN_PARAMS_SVH
`define FLASH_KEY_MARGIN_PARAMS_SVH
`define CMD_VERIFY_KEY      8'h0c
`define CMD_USER_MARGIN     8'h0d
`define CMD_FACTORY_MARGIN  8'h0e
`define IDX_KEY_LAST        3'h4
`define IDX_MARGIN_LAST     3'h2
`define KEY_ENABLED_CODE    2'h2
`define SEC_UNSECURED_CODE  2'h2
`define KEY_STORE_BASE      24'h000400
`define MARGIN_NORMAL       16'h0000
`define MARGIN_USER_MAX     16'h0002
`define MARGIN_FACTORY_MAX  16'h0004
`define COMPLETE_RESET      1'b1
`define SEC_RESET_CODE      2'h1
`define INDEX_RESET         3'h0
`define BLOCK_RESET         8'h00
`define PARAM_RESET         16'h0000
`endif

// *** flash_key_margin_pkg.sv ***
// types shared by the flash key and margin command block
// assumes nothing beyond a systemverilog compiler
package flash_key_margin_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_KEY   = 4'b0100,
    ST_DONE  = 4'b1000
  } seq_state_t;
endpackage : flash_key_margin_pkg

// *** flash_key_margin.sv ***
// flash command sequencer: backdoor key verify, user and factory margin level
// assumes software writes params only while cmd_complete_flag is set; stored keys on a plain input
`timescale 1ns/1ps
`include "flash_key_margin_params.svh"

// How it works
// R1: software loads code 0x0c at index 0, key words at indices 1 to 4.
// R2: clearing the command-complete flag launches the loaded command.
// R3: key verify proceeds only when key-enable equals 10, otherwise access error.
// R4: each key word is compared with the stored key starting at 0x0400.
// R5: all keys matching releases security.
// R6: mismatch sets access error and locks out key verify until reset.
// R7: key verify launched with index other than 100 gives access error.
// R8: command-complete flag sets when key verify finishes, whatever the result.
// R9: software runs the key verify routine from ram.
// R10: user margin: code 0x0d plus address at indices 0,1, setting at 2.
// R11: user margin applies the level to later reads of the block, then completes.
// R12: user margin accepts only settings 0, 1 and 2.
// R13: factory margin uses code 0x0e with the same layout.
// R14: factory margin applies the level to later reads of the block, then completes.
// R15: factory margin also accepts settings 3 and 4.
// R16: margin commands launched with index other than 010 give access error.
// R17: margin commands not allowed in the current mode give access error.
// R18: margin commands with an invalid block address give access error.
// R19: margin commands with an out-of-range setting give access error.
// R20: software uses factory margins only for initial factory verify.
// R21: released security reads as the unsecured code 10.
// R22: software writes no register while a command runs.
// R23: lockout and margin level return to unlocked and normal on reset.
module flash_key_margin #(
  parameter int NUM_BLOCKS = 1,
  parameter logic [7:0] BLOCK_BASE_HI = 8'h00
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        param_wr,
  input  wire logic [2:0]  param_index,
  input  wire logic [7:0]  cmd_param_high_byte,
  input  wire logic [7:0]  cmd_param_low_byte,
  input  wire logic        cmd_complete_clear,
  input  wire logic        access_error_clear,
  input  wire logic [1:0]  key_access_enable,
  input  wire logic [1:0]  security_init,
  input  wire logic [63:0] stored_key,
  input  wire logic        margin_cmd_allowed,
  output logic             cmd_complete_flag,
  output logic             access_error_flag,
  output logic [1:0]       security_state,
  output logic [2:0]       margin_level,
  output logic [7:0]       margin_block,
  output logic             key_locked
);

  logic [15:0] param_reg [0:4];
  flash_key_margin_pkg::seq_state_t state_reg;
  flash_key_margin_pkg::seq_state_t state_next;
  logic        complete_reg;
  logic        complete_next;
  logic        error_reg;
  logic        error_next;
  logic [1:0]  sec_reg;
  logic [1:0]  sec_next;
  logic        sec_loaded_reg;
  logic        sec_loaded_next;
  logic [2:0]  margin_reg;
  logic [2:0]  margin_next;
  logic [7:0]  mblock_reg;
  logic [7:0]  mblock_next;
  logic        lock_reg;
  logic        lock_next;
  logic [2:0]  index_reg;
  logic [2:0]  index_next;

  // a key word is 16 bits; the high byte sits at the address base + 2*k
  function automatic logic [15:0] stored_word(input logic [63:0] keys, input int k);
    stored_word = keys[k*16 +: 16];
  endfunction : stored_word

  // the factory command accepts the user settings and the two factory ones above them
  function automatic logic margin_setting_ok(input logic factory, input logic [15:0] setting);
    if (factory) begin
      margin_setting_ok = (setting <= `MARGIN_FACTORY_MAX); // R15
    end else begin
      margin_setting_ok = (setting <= `MARGIN_USER_MAX); // R12
    end
  endfunction : margin_setting_ok

  wire [7:0]  cmd_code    = param_reg[0][15:8];
  wire [23:0] global_addr = {param_reg[0][7:0], param_reg[1]};
  wire [15:0] margin_set  = param_reg[2];
  wire        is_key      = (cmd_code == `CMD_VERIFY_KEY);
  wire        is_user     = (cmd_code == `CMD_USER_MARGIN);
  wire        is_factory  = (cmd_code == `CMD_FACTORY_MARGIN);
  wire        is_margin   = is_user | is_factory;

  // key stored at KEY_STORE_BASE; comparison walks the four words
  logic [3:0] key_match;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_key
      assign key_match[g] = (param_reg[g+1] == stored_word(stored_key, g)); // R4
    end
  endgenerate
  wire keys_ok = &key_match;

  // each refusal is a named term, so a refused launch traces back to one cause
  wire        key_bad_index = (index_reg != `IDX_KEY_LAST);             // R7
  wire        key_disabled  = (key_access_enable != `KEY_ENABLED_CODE); // R3
  wire        key_err       = key_bad_index | key_disabled | lock_reg;  // R6

  // the block window is compared at 32 bits so base plus count cannot wrap
  wire [31:0] addr_hi       = {24'h000000, global_addr[23:16]};
  wire [31:0] range_lo      = {24'h000000, BLOCK_BASE_HI};
  wire [31:0] range_hi      = range_lo + 32'(NUM_BLOCKS);
  wire        addr_ok       = (addr_hi >= range_lo) && (addr_hi < range_hi); // R18
  wire        set_ok        = margin_setting_ok(is_factory, margin_set);     // R12 R15
  wire        m_bad_index   = (index_reg != `IDX_MARGIN_LAST);               // R16
  wire        m_bad_mode    = ~margin_cmd_allowed;                            // R17
  wire        m_bad_addr    = ~addr_ok;                                       // R18
  wire        m_bad_set     = ~set_ok;                                        // R19
  wire        margin_err    = m_bad_index | m_bad_mode | m_bad_addr | m_bad_set;
  wire        unknown_cmd   = ~is_key & ~is_margin;
  wire        cmd_err       = (is_key & key_err) | (is_margin & margin_err) | unknown_cmd;

  wire launch = cmd_complete_clear & complete_reg; // R2

  // idle, check, key compare only for an accepted key command, then done raises the flag
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      flash_key_margin_pkg::ST_IDLE: begin
        if (launch) begin
          state_next = flash_key_margin_pkg::ST_CHECK; // R2
        end
      end
      flash_key_margin_pkg::ST_CHECK: begin
        if (is_key && !cmd_err) begin
          state_next = flash_key_margin_pkg::ST_KEY;
        end else begin
          state_next = flash_key_margin_pkg::ST_DONE;
        end
      end
      flash_key_margin_pkg::ST_KEY: begin
        state_next = flash_key_margin_pkg::ST_DONE;
      end
      flash_key_margin_pkg::ST_DONE: begin
        state_next = flash_key_margin_pkg::ST_IDLE;
      end
      default: begin
        state_next = flash_key_margin_pkg::ST_IDLE;
      end
    endcase
  end

  wire in_check = (state_reg == flash_key_margin_pkg::ST_CHECK);
  wire in_key   = (state_reg == flash_key_margin_pkg::ST_KEY);
  wire in_done  = (state_reg == flash_key_margin_pkg::ST_DONE);
  wire raise_err = (in_check & cmd_err) | (in_key & ~keys_ok); // R6

  // index and parameter array; writes while busy are ignored as software must not make them
  wire param_open = param_wr & complete_reg;
  assign index_next = param_open ? param_index : index_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      index_reg <= `INDEX_RESET;
    end else begin
      index_reg <= index_next;
    end
  end

  for (g = 0; g < 5; g++) begin : g_param
    wire word_sel = param_open & (param_index == 3'(g));
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        param_reg[g] <= `PARAM_RESET;
      end else if (word_sel) begin
        param_reg[g] <= {cmd_param_high_byte, cmd_param_low_byte};
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= flash_key_margin_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // next values for every status register; the clocked blocks below only load them
  always_comb begin
    complete_next = complete_reg;
    if (in_done) begin
      complete_next = 1'b1; // R8
    end else if (launch) begin
      complete_next = 1'b0; // R2
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    error_next = error_reg;
    if (raise_err) begin
      error_next = 1'b1; // R3 R6 R7 R16 R17 R18 R19
    end else if (access_error_clear) begin
      error_next = 1'b0;
    end
  end

  // lockout is sticky: only reset lifts it
  always_comb begin
    lock_next = lock_reg;
    if (in_key && !keys_ok) begin
      lock_next = 1'b1; // R6
    end
  end

  // security is copied from its input on the first clock after release, never under reset,
  // so the reset branch stays a constant
  always_comb begin
    sec_next        = sec_reg;
    sec_loaded_next = 1'b1;
    if (!sec_loaded_reg) begin
      sec_next = security_init;
    end else if (in_key && keys_ok) begin
      sec_next = `SEC_UNSECURED_CODE; // R5 R21
    end
  end

  // a refused margin command leaves level and block as they were
  always_comb begin
    margin_next = margin_reg;
    mblock_next = mblock_reg;
    if (in_check && is_margin && !cmd_err) begin
      margin_next = margin_set[2:0]; // R11 R14
      mblock_next = global_addr[23:16];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      complete_reg <= `COMPLETE_RESET;
    end else begin
      complete_reg <= complete_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      error_reg <= 1'b0;
    end else begin
      error_reg <= error_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= 1'b0; // R23
    end else begin
      lock_reg <= lock_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec_reg <= `SEC_RESET_CODE;
    end else begin
      sec_reg <= sec_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec_loaded_reg <= 1'b0;
    end else begin
      sec_loaded_reg <= sec_loaded_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      margin_reg <= 3'(`MARGIN_NORMAL); // R23
    end else begin
      margin_reg <= margin_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mblock_reg <= `BLOCK_RESET;
    end else begin
      mblock_reg <= mblock_next;
    end
  end

  assign cmd_complete_flag = complete_reg;
  assign access_error_flag = error_reg;
  assign security_state    = sec_reg;
  assign margin_level      = margin_reg;
  assign margin_block      = mblock_reg;
  assign key_locked        = lock_reg;

endmodule : flash_key_margin

// *** flash_key_margin_assertions.sv ***
// port checker for the key and margin sequencer
// assumes a bind onto flash_key_margin, single clock
`timescale 1ns/1ps
`include "flash_key_margin_params.svh"
module flash_key_margin_assertions (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       param_wr,
  input wire logic [2:0] param_index,
  input wire logic [7:0] cmd_param_high_byte,
  input wire logic       cmd_complete_clear,
  input wire logic [1:0] key_access_enable,
  input wire logic       margin_cmd_allowed,
  input wire logic       cmd_complete_flag,
  input wire logic       access_error_flag,
  input wire logic [1:0] security_state,
  input wire logic [2:0] margin_level,
  input wire logic       key_locked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] cmd_reg;
  logic [2:0] idx_reg;
  wire        go = cmd_complete_flag && cmd_complete_clear;
  wire        unknown_code = (cmd_reg != `CMD_VERIFY_KEY) && (cmd_reg != `CMD_USER_MARGIN) &&
                             (cmd_reg != `CMD_FACTORY_MARGIN);
  // shadow of the loaded code and last index, written only while idle as the design takes them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= 8'h00;
      idx_reg <= 3'h0;
    end else if (param_wr && cmd_complete_flag) begin
      idx_reg <= param_index;
      cmd_reg <= (param_index == 3'h0) ? cmd_param_high_byte : cmd_reg;
    end
  end
  sequence err_s;
    ##[1:3] access_error_flag;
  endsequence
  a_launch_drops: assert property (go |=> !cmd_complete_flag) else $error("flag not cleared");
  a_done_bound: assert property ($fell(cmd_complete_flag) |-> ##[1:3] cmd_complete_flag) else $error("no done");
  a_idle_holds: assert property (cmd_complete_flag && !cmd_complete_clear |=> cmd_complete_flag) else $error("idle");
  a_key_refused: assert property (go && cmd_reg == `CMD_VERIFY_KEY &&
    (key_access_enable != `KEY_ENABLED_CODE || key_locked || idx_reg != `IDX_KEY_LAST) |-> err_s)
    else $error("key not refused");
  a_margin_refused: assert property (go && (cmd_reg == `CMD_USER_MARGIN ||
    cmd_reg == `CMD_FACTORY_MARGIN) && (!margin_cmd_allowed || idx_reg != `IDX_MARGIN_LAST) |-> err_s)
    else $error("margin not refused");
  a_code_refused: assert property (go && unknown_code |-> err_s) else $error("unknown code not refused");
  a_sec_release: assert property ($changed(security_state) && !$past(cmd_complete_flag) |->
    security_state == `SEC_UNSECURED_CODE) else $error("bad security");
  a_lock_error: assert property ($rose(key_locked) |-> access_error_flag && $stable(security_state))
    else $error("lock without error");
  a_lock_holds: assert property (key_locked |=> key_locked) else $error("lock lost");
  a_level_cmd: assert property ($changed(margin_level) |->
    !$past(cmd_complete_flag) && margin_level <= 3'h4) else $error("level change");
endmodule : flash_key_margin_assertions

// *** test_flash_key_margin.sv ***
// self-checking bench for the key and margin sequencer
// assumes the design and checker are compiled before this file
`timescale 1ns/1ps
`include "flash_key_margin_params.svh"
module test_flash_key_margin;
  logic        mclk, reset_n, param_wr, cmd_complete_clear, access_error_clear, margin_cmd_allowed;
  logic        cmd_complete_flag, access_error_flag, key_locked, l_exp;
  logic [2:0]  param_index, margin_level, m_exp;
  logic [7:0]  cmd_param_high_byte, cmd_param_low_byte, margin_block, b_exp;
  logic [1:0]  key_access_enable, security_init, security_state, s_exp;
  logic [63:0] stored_key;
  int          n_fail, num_checks;
  flash_key_margin dut (.mclk, .reset_n, .param_wr, .param_index, .cmd_param_high_byte, .cmd_param_low_byte,
    .cmd_complete_clear, .access_error_clear, .key_access_enable, .security_init, .stored_key,
    .margin_cmd_allowed, .cmd_complete_flag, .access_error_flag, .security_state, .margin_level,
    .margin_block, .key_locked);
  always #12.5 mclk = ~mclk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  // index 0 write also clears a stale error so each command is judged alone
  task automatic wr(input logic [2:0] idx, input logic [15:0] w);
    @(posedge mclk);
    #2;
    {param_wr, param_index, cmd_param_high_byte, cmd_param_low_byte} = {1'b1, idx, w};
    access_error_clear = (idx == 3'h0);
    @(posedge mclk);
    #2;
    {param_wr, access_error_clear} = 2'b00;
  endtask : wr
  task automatic go;
    @(posedge mclk);
    #2;
    cmd_complete_clear = 1'b1;
    @(posedge mclk);
    #2;
    cmd_complete_clear = 1'b0;
    chk("busy", 16'h0, cmd_complete_flag);
    repeat (3) @(posedge mclk);
    #2;
    chk("done", 16'h1, cmd_complete_flag);
  endtask : go
  function automatic logic m_bad(input logic [7:0] cmd, blk, input logic [15:0] lvl, input bit full, allow);
    return !full || !allow || blk != 8'h00 || (cmd != `CMD_USER_MARGIN && cmd != `CMD_FACTORY_MARGIN) ||
      lvl > (cmd == `CMD_USER_MARGIN ? `MARGIN_USER_MAX : `MARGIN_FACTORY_MAX);
  endfunction : m_bad
  task automatic margin(input logic [7:0] cmd, blk, input logic [15:0] lvl, input bit full, allow);
    logic bad;
    bad = m_bad(cmd, blk, lvl, full, allow);
    margin_cmd_allowed = allow;
    wr(3'h0, {cmd, blk});
    wr(3'h1, 16'($urandom));
    if (full) wr(3'h2, lvl);
    go();
    if (!bad) {m_exp, b_exp} = {lvl[2:0], blk};
    chk("margin error", 16'(bad), access_error_flag);
    chk("margin level", 16'(m_exp), margin_level);
    chk("margin block", 16'(b_exp), margin_block);
  endtask : margin
  task automatic key(input int n, input logic [15:0] flip, input logic [1:0] ken);
    logic ok;
    ok = ken == `KEY_ENABLED_CODE && n == 4 && !l_exp;
    key_access_enable = ken;
    wr(3'h0, {`CMD_VERIFY_KEY, 8'h00});
    for (int k = 0; k < n; k++) wr(3'(k + 1), stored_key[16*k +: 16] ^ (k == 2 ? flip : 16'h0));
    go();
    l_exp = l_exp || (ok && flip != 16'h0);
    ok = ok && flip == 16'h0;
    if (ok) s_exp = `SEC_UNSECURED_CODE;
    chk("key error", 16'(!ok), access_error_flag);
    chk("security", 16'(s_exp), security_state);
    chk("lockout", 16'(l_exp), key_locked);
  endtask : key
  task automatic rst;
    reset_n = 1'b0;
    repeat (4) @(posedge mclk);
    chk("reset lock", 16'h0, key_locked);
    chk("reset level", 16'h0, margin_level);
    #2;
    reset_n = 1'b1;
    {m_exp, b_exp, l_exp, s_exp} = {3'h0, 8'h00, 1'b0, security_init};
    @(posedge mclk);
  endtask : rst
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    {mclk, param_wr, cmd_complete_clear, access_error_clear, param_index, key_access_enable} = '0;
    {cmd_param_high_byte, cmd_param_low_byte, margin_cmd_allowed, security_init} = {16'h0, 1'b1, 2'h1};
    {n_fail, num_checks} = '0;
    void'($urandom(51));
    stored_key = {$urandom, $urandom};
    rst();
    for (int s = 0; s < 6; s++) margin(`CMD_USER_MARGIN, 8'h00, 16'(s), 1, 1);
    for (int s = 0; s < 6; s++) margin(`CMD_FACTORY_MARGIN, 8'h00, 16'(s), 1, 1);
    margin(`CMD_FACTORY_MARGIN, 8'h01, 16'h3, 1, 1);
    margin(8'h0b, 8'h00, 16'h1, 1, 1);
    repeat (16) margin($urandom_range(0, 1) ? `CMD_USER_MARGIN : `CMD_FACTORY_MARGIN, 8'($urandom_range(0, 3) == 0),
      16'($urandom_range(0, 6)), 1'($urandom_range(0, 4) != 0), 1'($urandom_range(0, 4) != 0));
    for (int e = 0; e < 4; e++) key(4, 16'h0, 2'(e));
    key(3, 16'h0, 2'h2);
    security_init = 2'h3;
    rst();
    key(4, 16'h0040, 2'h2);
    key(4, 16'h0, 2'h2);
    rst();
    key(4, 16'h0, 2'h2);
    wrap_up();
  end
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
endmodule : test_flash_key_margin
bind flash_key_margin flash_key_margin_assertions chk_i (.mclk, .reset_n, .param_wr, .param_index,
  .cmd_param_high_byte, .cmd_complete_clear, .key_access_enable, .margin_cmd_allowed, .cmd_complete_flag,
  .access_error_flag, .security_state, .margin_level, .key_locked);
